// >>> rtl/fsp_flash_security.sv
// Security, configuration and protection registers of the flash controller
`timescale 1ns/1ns
`default_nettype none
module fsp_flash_security (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] nvm_lock_byte,
   input wire logic [7:0] nvm_prot_byte,
   input wire logic special_mode,
   input wire logic backdoor_unsecure,
   input wire logic cmd_buffer_empty_flag,
   input wire logic all_done_flag,
   input wire logic array_wr,
   input wire logic array_rd,
   input wire logic cmd_req,
   input wire logic [1:0] cmd_kind,
   input wire logic [14:0] cmd_addr,
   output logic regs_loaded,
   output logic backdoor_enabled,
   output logic unsecured,
   output logic buffer_empty_irq,
   output logic complete_irq,
   output logic cmd_seq_start,
   output logic key_word_wr,
   output logic array_rd_grant,
   output logic cmd_go,
   output logic protect_violation_flag_set
);
   fsp_pkg::fsp_state_type s_reg;
   fsp_pkg::fsp_state_type s_next;

   // ----------------------------------------
   // Protection decode
   // ----------------------------------------
   function automatic logic [5:0] low_kb(input logic [2:0] code);
      logic [5:0] kb;
      kb = fsp_pkg::FSP_ARRAY_KB;
      case (code)
         3'h3: kb = 6'h04;
         3'h4: kb = 6'h03;
         3'h5: kb = 6'h02;
         3'h6: kb = 6'h01;
         3'h7: kb = 6'h00;
         default: kb = fsp_pkg::FSP_ARRAY_KB; // Reserved codes act as whole array
      endcase
      return kb;
   endfunction

   function automatic logic [5:0] up_kb(input logic [4:0] code);
      if (code == fsp_pkg::FSP_UP_NONE) begin
         return 6'h00;
      end
      return 6'h1F - {1'b0, code};
   endfunction

   function automatic logic addr_protected(input logic [7:0] prot, input logic [14:0] a);
      logic up_hit;
      logic lo_hit;
      up_hit = (prot[7:3] != fsp_pkg::FSP_UP_NONE) && (a[14:10] > prot[7:3]);
      lo_hit = ({1'b0, a[14:10]} < low_kb(prot[2:0]));
      return up_hit || lo_hit;
   endfunction

   logic any_prot;
   logic grows;
   logic hit;
   assign any_prot = (s_reg.prot_reg[7:3] != fsp_pkg::FSP_UP_NONE) ||
                     (s_reg.prot_reg[2:0] != fsp_pkg::FSP_LO_NONE);
   assign grows = (up_kb(reg_wdata[7:3]) >= up_kb(s_reg.prot_reg[7:3])) &&
                  (low_kb(reg_wdata[2:0]) >= low_kb(s_reg.prot_reg[2:0]));
   assign hit = addr_protected(s_reg.prot_reg, cmd_addr);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic run;
      logic [7:0] lock_n;
      run = (s_reg.phase == fsp_pkg::FSP_RUN);
      lock_n = s_reg.lock_reg;
      s_next = s_reg;
      s_next.rdata = 8'h00;
      s_next.cmd_start = 1'b0;
      s_next.key_wr = 1'b0;
      s_next.rd_grant = 1'b0;
      s_next.cmd_go = 1'b0;
      s_next.viol = 1'b0;

      unique case (s_reg.phase)
         fsp_pkg::FSP_LOAD: begin
            // Caught after release so no port feeds the async reset path
            lock_n = nvm_lock_byte;
            s_next.prot_reg = nvm_prot_byte;
            s_next.phase = fsp_pkg::FSP_RUN;
            s_next.loaded = 1'b1;
         end
         fsp_pkg::FSP_RUN: begin
            if (backdoor_unsecure) begin
               lock_n[1:0] = fsp_pkg::FSP_UNSECURED;
            end
            if (reg_wr && reg_addr == fsp_pkg::FSP_OFF_CFG) begin
               s_next.cfg_reg[7:6] = reg_wdata[7:6];
               if (s_reg.bd_en) begin
                  s_next.cfg_reg[fsp_pkg::FSP_BIT_KEY_MODE] =
                     reg_wdata[fsp_pkg::FSP_BIT_KEY_MODE];
               end
            end
            if (reg_wr && reg_addr == fsp_pkg::FSP_OFF_PROT && (special_mode || grows)) begin
               s_next.prot_reg = reg_wdata;
            end
            if (reg_rd) begin
               case (reg_addr)
                  fsp_pkg::FSP_OFF_LOCK: s_next.rdata = s_reg.lock_reg;
                  fsp_pkg::FSP_OFF_CFG: s_next.rdata = s_reg.cfg_reg & fsp_pkg::FSP_CFG_WMASK;
                  fsp_pkg::FSP_OFF_PROT: s_next.rdata = s_reg.prot_reg;
                  default: s_next.rdata = 8'h00; // Reserved byte and holes read zero
               endcase
            end
            if (array_wr) begin
               if (s_reg.cfg_reg[fsp_pkg::FSP_BIT_KEY_MODE]) begin
                  s_next.key_wr = 1'b1;
               end else begin
                  s_next.cmd_start = 1'b1;
               end
            end
            s_next.rd_grant = array_rd; // Reads never gated by key mode
            if (cmd_req) begin
               if (fsp_pkg::fsp_cmd_type'(cmd_kind) == fsp_pkg::FSP_CMD_MASS_ERASE) begin
                  s_next.cmd_go = !any_prot;
                  s_next.viol = any_prot;
               end else if (fsp_pkg::fsp_cmd_type'(cmd_kind) == fsp_pkg::FSP_CMD_OTHER) begin
                  s_next.cmd_go = 1'b1;
               end else begin
                  s_next.cmd_go = !hit;
                  s_next.viol = hit;
               end
            end
         end
      endcase
      // Lock register has no bus write path; after the load only backdoor_unsecure changes its low bits
      s_next.lock_reg = lock_n;
      s_next.bd_en = run || s_reg.phase == fsp_pkg::FSP_LOAD ?
                     (lock_n[7:6] == fsp_pkg::FSP_BD_ENABLED) : 1'b0;
      s_next.unsec = (lock_n[1:0] == fsp_pkg::FSP_UNSECURED);
      s_next.cbe_irq = s_next.cfg_reg[fsp_pkg::FSP_BIT_CBE_EN] && cmd_buffer_empty_flag;
      s_next.cc_irq = s_next.cfg_reg[fsp_pkg::FSP_BIT_CC_EN] && all_done_flag;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '{phase: fsp_pkg::FSP_LOAD, lock_reg: fsp_pkg::FSP_LOCK_RESET,
                    cfg_reg: fsp_pkg::FSP_CFG_RESET, prot_reg: fsp_pkg::FSP_PROT_RESET,
                    default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata = s_reg.rdata;
   assign regs_loaded = s_reg.loaded;
   assign backdoor_enabled = s_reg.bd_en;
   assign unsecured = s_reg.unsec;
   assign buffer_empty_irq = s_reg.cbe_irq;
   assign complete_irq = s_reg.cc_irq;
   assign cmd_seq_start = s_reg.cmd_start;
   assign key_word_wr = s_reg.key_wr;
   assign array_rd_grant = s_reg.rd_grant;
   assign cmd_go = s_reg.cmd_go;
   assign protect_violation_flag_set = s_reg.viol;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   a_lock_no_write: assert property ((reg_wr && !backdoor_unsecure && s_reg.loaded) |=>
      s_reg.lock_reg == $past(s_reg.lock_reg)) else $error("lock register changed by write");
   a_lock_loaded: assert property ((s_reg.phase == fsp_pkg::FSP_LOAD) |=>
      (s_reg.lock_reg == $past(nvm_lock_byte) && regs_loaded)) else $error("lock not loaded");
   a_bd_decode: assert property (s_reg.loaded |->
      backdoor_enabled == (s_reg.lock_reg[7:6] == 2'h2)) else $error("backdoor decode wrong");
   a_unsec_decode: assert property (unsecured == (s_reg.lock_reg[1:0] == 2'h2))
      else $error("lock state decode wrong");
   a_unsec_force: assert property ((backdoor_unsecure && s_reg.loaded) |=>
      unsecured ##1 unsecured) else $error("backdoor did not unsecure");
   a_rsvd_zero: assert property ((reg_rd && reg_addr == 16'h0102) |=> reg_rdata == 8'h00)
      else $error("reserved byte not zero");
   a_cfg_low_zero: assert property ((reg_rd && reg_addr == 16'h0103) |=>
      reg_rdata[4:0] == 5'h00) else $error("config low bits not zero");
   a_key_mode_gate: assert property ((reg_wr && reg_addr == 16'h0103 && !backdoor_enabled) |=>
      $stable(s_reg.cfg_reg[5])) else $error("key mode written while disabled");
   a_cbe_irq: assert property (buffer_empty_irq ==
      (s_reg.cfg_reg[7] && $past(cmd_buffer_empty_flag))) else $error("buffer empty irq wrong");
   a_cc_irq: assert property ((!s_reg.cfg_reg[6] && !$past(s_reg.cfg_reg[6])) |->
      !complete_irq) else $error("complete irq without enable");
   a_key_redirect: assert property ((array_wr && s_reg.loaded && s_reg.cfg_reg[5]) |=>
      (key_word_wr && !cmd_seq_start)) else $error("key write not redirected");
   a_read_served: assert property ((array_rd && s_reg.loaded) |=> array_rd_grant)
      else $error("array read dropped");
   a_prot_grow: assert property ((reg_wr && reg_addr == 16'h0104 && !special_mode && !grows
      && s_reg.loaded) |=> $stable(s_reg.prot_reg)) else $error("protection shrank");
   a_prot_block: assert property ((cmd_req && s_reg.loaded && hit && cmd_kind != 2'h3) |=>
      (!cmd_go && protect_violation_flag_set)) else $error("protected command not blocked");
   a_mass_refuse: assert property ((cmd_req && s_reg.loaded && any_prot && cmd_kind == 2'h2) |=>
      !cmd_go) else $error("mass erase under protection");

   // ----------------------------------------
   // Reference protection decode
   // ----------------------------------------
   // Kept as address bounds, apart from the kbyte functions, so one slip
   // cannot hide in both the logic and its check
   logic [15:0] ref_up_start;
   logic [15:0] ref_lo_end;
   logic ref_hit;

   always_comb begin
      ref_up_start = 16'h8000;
      ref_lo_end = 16'h8000;
      if (s_reg.prot_reg[7:3] != 5'h1F) begin
         ref_up_start = {1'b0, s_reg.prot_reg[7:3] + 5'h01, 10'h000};
      end
      case (s_reg.prot_reg[2:0])
         3'h3: ref_lo_end = 16'h1000;
         3'h4: ref_lo_end = 16'h0C00;
         3'h5: ref_lo_end = 16'h0800;
         3'h6: ref_lo_end = 16'h0400;
         3'h7: ref_lo_end = 16'h0000;
         default: ref_lo_end = 16'h8000;
      endcase
      ref_hit = ({1'b0, cmd_addr} >= ref_up_start) || ({1'b0, cmd_addr} < ref_lo_end);
   end

   // ----------------------------------------
   // Command check assertions
   // ----------------------------------------
   a_prot_ref: assert property (
      (cmd_req && s_reg.loaded && !cmd_kind[1]) |=>
      (protect_violation_flag_set == $past(ref_hit)))
      else $error("protection differs from address bounds");

   a_lo_reserved: assert property (
      (cmd_req && s_reg.loaded && !cmd_kind[1] && s_reg.prot_reg[2:0] inside {3'h0, 3'h1, 3'h2})
      |=> (protect_violation_flag_set && !cmd_go))
      else $error("reserved lower code did not protect all");

   a_top_kbyte: assert property (
      (cmd_req && s_reg.loaded && !cmd_kind[1] && s_reg.prot_reg[7:3] == 5'h1E &&
      cmd_addr[14:10] == 5'h1F) |=> protect_violation_flag_set)
      else $error("top kbyte not protected");

   a_no_protect: assert property (
      (cmd_req && s_reg.loaded && s_reg.prot_reg == 8'hFF) |=>
      (cmd_go && !protect_violation_flag_set))
      else $error("command refused without protection");

   a_mass_free: assert property (
      (cmd_req && s_reg.loaded && !any_prot && cmd_kind == 2'h2) |=>
      (cmd_go && !protect_violation_flag_set))
      else $error("mass erase refused while unprotected");

   a_mass_viol: assert property (
      (cmd_req && s_reg.loaded && any_prot && cmd_kind == 2'h2) |=>
      protect_violation_flag_set)
      else $error("refused mass erase not flagged");

   a_other_go: assert property (
      (cmd_req && s_reg.loaded && cmd_kind == 2'h3) |=>
      (cmd_go && !protect_violation_flag_set))
      else $error("other command refused");

   a_viol_excl: assert property (
      !(cmd_go && protect_violation_flag_set))
      else $error("go and violation together");

   a_no_req_idle: assert property (
      !cmd_req |=>
      (!cmd_go && !protect_violation_flag_set))
      else $error("command result without request");

   // ----------------------------------------
   // Register assertions
   // ----------------------------------------
   a_prot_special: assert property (
      (reg_wr && reg_addr == 16'h0104 && special_mode && s_reg.loaded) |=>
      (s_reg.prot_reg == $past(reg_wdata)))
      else $error("special mode protection write lost");

   a_prot_accept: assert property (
      (reg_wr && reg_addr == 16'h0104 && grows && s_reg.loaded) |=>
      (s_reg.prot_reg == $past(reg_wdata)))
      else $error("growing protection write lost");

   a_prot_shrink_up: assert property (
      (reg_wr && reg_addr == 16'h0104 && !special_mode && s_reg.loaded &&
      reg_wdata[7:3] > s_reg.prot_reg[7:3]) |=> $stable(s_reg.prot_reg))
      else $error("upper range shrank");

   a_prot_loaded: assert property (
      (s_reg.phase == fsp_pkg::FSP_LOAD) |=>
      (s_reg.prot_reg == $past(nvm_prot_byte)))
      else $error("protection not loaded");

   a_prot_read: assert property (
      (reg_rd && reg_addr == 16'h0104 && s_reg.loaded) |=>
      (reg_rdata == $past(s_reg.prot_reg)))
      else $error("protection read wrong");

   a_lock_read: assert property (
      (reg_rd && reg_addr == 16'h0101 && s_reg.loaded) |=>
      (reg_rdata == $past(s_reg.lock_reg)))
      else $error("lock read wrong");

   a_lock_only_unsec: assert property (
      (s_reg.loaded && !backdoor_unsecure) |=>
      $stable(s_reg.lock_reg))
      else $error("lock changed without unsecure");

   a_loaded_stay: assert property (
      regs_loaded |=>
      regs_loaded)
      else $error("loaded flag dropped");

   a_cfg_write: assert property (
      (reg_wr && reg_addr == 16'h0103 && s_reg.loaded) |=>
      (s_reg.cfg_reg[7:6] == $past(reg_wdata[7:6])))
      else $error("config enables not written");

   a_cfg_low_reg: assert property (
      s_reg.cfg_reg[4:0] == 5'h00)
      else $error("config low bits stored");

   a_cfg_reset: assert property (
      (s_reg.phase == fsp_pkg::FSP_LOAD) |->
      (s_reg.cfg_reg == 8'h00))
      else $error("config not zero after reset");

   a_key_mode_set: assert property (
      (reg_wr && reg_addr == 16'h0103 && backdoor_enabled) |=>
      (s_reg.cfg_reg[5] == $past(reg_wdata[5])))
      else $error("key mode write lost");

   a_bd_disabled: assert property (
      (s_reg.loaded && s_reg.lock_reg[7:6] != 2'h2) |->
      !backdoor_enabled)
      else $error("backdoor enabled by wrong code");

   a_unsec_hold: assert property (
      (s_reg.loaded && unsecured) |=>
      unsecured)
      else $error("unsecured state lost");

   a_rdata_idle: assert property (
      !reg_rd |=>
      (reg_rdata == 8'h00))
      else $error("read data without read");

   // ----------------------------------------
   // Array and interrupt assertions
   // ----------------------------------------
   a_cmd_redirect: assert property (
      (array_wr && s_reg.loaded && !s_reg.cfg_reg[5]) |=>
      (cmd_seq_start && !key_word_wr))
      else $error("array write not taken as command");

   a_no_array_idle: assert property (
      !array_wr |=>
      (!cmd_seq_start && !key_word_wr))
      else $error("array result without write");

   a_read_pulse: assert property (
      !array_rd |=>
      !array_rd_grant)
      else $error("read grant without read");

   a_cbe_off: assert property (
      !s_reg.cfg_reg[7] |->
      !buffer_empty_irq)
      else $error("buffer empty irq without enable");

   a_cc_follow: assert property (
      complete_irq ==
      (s_reg.cfg_reg[6] && $past(all_done_flag)))
      else $error("complete irq wrong");
endmodule
`default_nettype wire

// >>> rtl/fsp_pkg.sv
// Package of constants and types for the flash security and protection block
package fsp_pkg;
   localparam logic [15:0] FSP_OFF_LOCK = 16'h0101;
   localparam logic [15:0] FSP_OFF_RSVD = 16'h0102;
   localparam logic [15:0] FSP_OFF_CFG = 16'h0103;
   localparam logic [15:0] FSP_OFF_PROT = 16'h0104;

   localparam int FSP_BIT_CBE_EN = 7;
   localparam int FSP_BIT_CC_EN = 6;
   localparam int FSP_BIT_KEY_MODE = 5;
   localparam logic [7:0] FSP_CFG_WMASK = 8'hE0;
   localparam logic [7:0] FSP_CFG_RESET = 8'h00;
   localparam logic [7:0] FSP_LOCK_RESET = 8'h00;
   localparam logic [7:0] FSP_PROT_RESET = 8'h00;

   localparam logic [1:0] FSP_BD_ENABLED = 2'h2;
   localparam logic [1:0] FSP_UNSECURED = 2'h2;
   localparam logic [4:0] FSP_UP_NONE = 5'h1F;
   localparam logic [2:0] FSP_LO_NONE = 3'h7;
   localparam logic [5:0] FSP_ARRAY_KB = 6'h20;

   typedef enum logic [1:0] {FSP_CMD_PROGRAM, FSP_CMD_SECTOR_ERASE, FSP_CMD_MASS_ERASE,
      FSP_CMD_OTHER} fsp_cmd_type;
   typedef enum {FSP_LOAD, FSP_RUN} fsp_phase_type;

   typedef struct packed {
      fsp_phase_type phase;
      logic [7:0] lock_reg;
      logic [7:0] cfg_reg;
      logic [7:0] prot_reg;
      logic [7:0] rdata;
      logic loaded;
      logic bd_en;
      logic unsec;
      logic cbe_irq;
      logic cc_irq;
      logic cmd_start;
      logic key_wr;
      logic rd_grant;
      logic cmd_go;
      logic viol;
   } fsp_state_type;
endpackage

// >>> dv/fsp_flash_model.sv
// Behavioural flash command engine that drives the status flags
`timescale 1ns/1ns
`default_nettype none
module fsp_flash_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cmd_go,
   output logic cmd_buffer_empty_flag,
   output logic all_done_flag
);
   logic [2:0] busy_reg;
   // Buffer frees before the command ends, so the two flags differ
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_reg <= 3'h0;
      end else if (cmd_go) begin
         busy_reg <= 3'h5;
      end else if (busy_reg != 3'h0) begin
         busy_reg <= busy_reg - 3'h1;
      end
   end
   assign cmd_buffer_empty_flag = (busy_reg < 3'h3);
   assign all_done_flag = (busy_reg == 3'h0);
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench of the flash security and protection block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] nvm_lock_byte = 8'h00;
   logic [7:0] nvm_prot_byte = 8'h00;
   logic [7:0] reg_rdata;
   logic reg_wr = 1'h0, reg_rd = 1'h0, special_mode = 1'h0, backdoor_unsecure = 1'h0;
   logic array_wr = 1'h0, array_rd = 1'h0, cmd_req = 1'h0;
   logic [1:0] cmd_kind = 2'h0;
   logic [14:0] cmd_addr = 15'h0000;
   logic cbe, done, loaded, bd_en, unsec, cbe_irq, cc_irq, seq, key, grant, go, viol;
   int fail_count = 0;
   int n_tests = 0;
   always #50 clk = ~clk;
   fsp_flash_security fsp_flash_security_inst (.clk(clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .nvm_lock_byte(nvm_lock_byte), .nvm_prot_byte(nvm_prot_byte),
      .special_mode(special_mode), .backdoor_unsecure(backdoor_unsecure),
      .cmd_buffer_empty_flag(cbe), .all_done_flag(done), .array_wr(array_wr),
      .array_rd(array_rd), .cmd_req(cmd_req), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
      .regs_loaded(loaded), .backdoor_enabled(bd_en), .unsecured(unsec),
      .buffer_empty_irq(cbe_irq), .complete_irq(cc_irq), .cmd_seq_start(seq),
      .key_word_wr(key), .array_rd_grant(grant), .cmd_go(go),
      .protect_violation_flag_set(viol));
   fsp_flash_model fsp_flash_model_inst (.clk(clk), .rst_b(rst_b), .cmd_go(go),
      .cmd_buffer_empty_flag(cbe), .all_done_flag(done));
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic do_reset(input logic [7:0] lock);
      @(posedge clk);
      rst_b <= 1'h0;
      nvm_lock_byte <= lock;
      nvm_prot_byte <= 8'hFF;
      repeat (6) @(posedge clk);
      rst_b <= 1'h1;
      repeat (2) @(posedge clk);
      #1 chk("loaded", 8'(loaded), 8'h01);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic s = 1'h0);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      special_mode <= s;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 chk("reg_rdata", reg_rdata, e);
   endtask
   task automatic cmd(input logic [1:0] k, input logic [14:0] a, input logic e);
      @(posedge clk);
      cmd_req <= 1'h1;
      cmd_kind <= k;
      cmd_addr <= a;
      @(posedge clk);
      cmd_req <= 1'h0;
      #1 chk("cmd_go", 8'(go), 8'(e));
      chk("violation", 8'(viol), 8'(!e));
   endtask
   task automatic arr(input logic w, input logic ek);
      @(posedge clk);
      array_wr <= w;
      array_rd <= !w;
      @(posedge clk);
      array_wr <= 1'h0;
      array_rd <= 1'h0;
      #1 chk("cmd_seq_start", 8'(seq), 8'(w && !ek));
      chk("key_word_wr", 8'(key), 8'(w && ek));
      chk("array_rd_grant", 8'(grant), 8'(!w));
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic lock_and_regs();
      logic [7:0] pw[8] = '{8'hF6, 8'hFF, 8'hF7, 8'hEE, 8'hF5, 8'hEE, 8'hFF, 8'hF6};
      logic [7:0] pe[8] = '{8'hF6, 8'hF6, 8'hF6, 8'hEE, 8'hEE, 8'hEE, 8'hFF, 8'hF6};
      do_reset(8'hC1);
      chk("bd_en", 8'(bd_en), 8'h00);
      chk("unsec", 8'(unsec), 8'h00);
      rd(16'h0104, 8'hFF);
      rd(16'h0100, 8'h00);
      wr(16'h0101, 8'h00);
      rd(16'h0101, 8'hC1);
      wr(16'h0102, 8'hFF);
      rd(16'h0102, 8'h00);
      wr(16'h0103, 8'hFF);
      rd(16'h0103, 8'hC0);
      @(posedge clk);
      backdoor_unsecure <= 1'h1;
      @(posedge clk);
      backdoor_unsecure <= 1'h0;
      rd(16'h0101, 8'hC2);
      chk("unsec", 8'(unsec), 8'h01);
      arr(1'h1, 1'h0);
      arr(1'h0, 1'h0);
      foreach (pw[i]) begin
         wr(16'h0104, pw[i], i > 5);
         rd(16'h0104, pe[i]);
      end
   endtask
   task automatic irq(input logic [7:0] c);
      logic fc, fd;
      wr(16'h0103, c);
      cmd(2'h3, 15'h0000, 1'h1);
      repeat (8) begin
         fc = cbe;
         fd = done;
         @(posedge clk);
         #1 chk("cbe_irq", 8'(cbe_irq), 8'(c[7] & fc));
         chk("cc_irq", 8'(cc_irq), 8'(c[6] & fd));
      end
   endtask
   task automatic protect_cmds();
      wr(16'h0104, 8'hF6, 1'h1);
      cmd(2'h0, 15'h7C00, 1'h0);
      cmd(2'h0, 15'h7BFF, 1'h1);
      cmd(2'h1, 15'h03FF, 1'h0);
      cmd(2'h1, 15'h0400, 1'h1);
      cmd(2'h2, 15'h0000, 1'h0);
      wr(16'h0104, 8'hFF, 1'h1);
      cmd(2'h2, 15'h0000, 1'h1);
      wr(16'h0104, 8'hF9, 1'h1);
      cmd(2'h0, 15'h7FFF, 1'h0);
      wr(16'h0104, 8'hFA, 1'h1);
      cmd(2'h0, 15'h4000, 1'h0);
      wr(16'h0104, 8'hFB, 1'h1);
      cmd(2'h0, 15'h0FFF, 1'h0);
      cmd(2'h0, 15'h1000, 1'h1);
      wr(16'h0104, 8'h07, 1'h1);
      cmd(2'h0, 15'h03FF, 1'h1);
      cmd(2'h0, 15'h0400, 1'h0);
   endtask
   task automatic key_mode();
      do_reset(8'h40);
      chk("bd_en", 8'(bd_en), 8'h00);
      wr(16'h0103, 8'h20);
      rd(16'h0103, 8'h00);
      do_reset(8'h82);
      chk("bd_en", 8'(bd_en), 8'h01);
      chk("unsec", 8'(unsec), 8'h01);
      wr(16'h0103, 8'h20);
      rd(16'h0103, 8'h20);
      arr(1'h1, 1'h1);
      arr(1'h0, 1'h1);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      lock_and_regs();
      irq(8'hC0);
      irq(8'h80);
      irq(8'h40);
      irq(8'h00);
      protect_cmds();
      key_mode();
      test_done();
   end
endmodule
`default_nettype wire
